// File: hw/pcir_pkg.sv
// Constants, register map and field layout for the page, command and interrupt register front end.
package pcir_pkg;
    // Register offsets inside a page; page selection sits at offset zero of every page.
    localparam logic [3:0] OFS_PAGE_SELECT  = 4'h0;
    localparam logic [3:0] OFS_COMMAND      = 4'h1;
    localparam logic [3:0] OFS_IRQ_EN_PRI   = 4'h2;
    localparam logic [3:0] OFS_IRQ_EN_SEC   = 4'h3;
    localparam logic [3:0] OFS_IRQ_REQ_PRI  = 4'h4;
    localparam logic [1:0] PAGE_ZERO        = 2'h0;
    // Reset values.
    localparam logic [7:0] RST_PAGE_SELECT  = 8'h00;
    localparam logic [7:0] RST_COMMAND      = 8'h20;
    localparam logic [7:0] RST_IRQ_EN_PRI   = 8'h80;
    localparam logic [7:0] RST_IRQ_EN_SEC   = 8'h00;
    localparam logic [7:0] RST_IRQ_REQ_PRI  = 8'h14;
    // Implemented bit masks; every other bit is reserved and stays zero.
    localparam logic [7:0] MASK_PAGE_SELECT = 8'h83;
    localparam logic [7:0] MASK_COMMAND     = 8'h3F;
    localparam logic [7:0] MASK_IRQ_EN_SEC  = 8'h9F;
    // Field positions.
    localparam int BIT_PAGE_OVERRIDE  = 7;
    localparam int BIT_RX_OFF         = 5;
    localparam int BIT_SLEEP          = 4;
    localparam int BIT_PIN_INVERT     = 7;
    localparam int BIT_PIN_CMOS       = 7;
    localparam int BIT_SET_CLEAR_SEL  = 7;
    localparam int BIT_TX_DONE        = 6;
    localparam int BIT_RX_DONE        = 5;
    localparam int BIT_IDLE           = 4;
    localparam int BIT_FIFO_HIGH      = 3;
    localparam int BIT_FIFO_LOW       = 2;
    localparam int BIT_ERROR          = 1;
    localparam int BIT_TIMER          = 0;
    // Command codes that this block itself must recognise.
    localparam logic [3:0] CMD_IDLE       = 4'h0;
    localparam logic [3:0] CMD_SOFT_RESET = 4'hF;
    // FIFO depth used by the high level comparison.
    localparam logic [6:0] FIFO_DEPTH     = 7'h40;
    // Soft sleep sequencing states.
    typedef enum logic [1:0] {PCIR_PWR_RUN, PCIR_PWR_SLEEP, PCIR_PWR_WAKE} pcir_pwr_t;
endpackage

// File: hw/pcir_regs.sv
// Page select, command and interrupt enable/request registers with the interrupt pin driver.
`timescale 1ns/1ps
`default_nettype none
module pcir_regs
    import pcir_pkg::*;
#(
    parameter logic [15:0] KNOWN_CMD_MASK = 16'hFFFF  // One bit per command code that the core accepts.
) (
    input  wire  logic       sys_clk_in,                // Core clock, 20 MHz.
    input  wire  logic       arst_n_in,                 // Asynchronous reset, active low.
    input  wire  logic       host_wr_in,                // One-cycle register write strobe.
    input  wire  logic       host_rd_in,                // One-cycle register read strobe.
    input  wire  logic [5:0] host_latch_addr_in,        // Internal address latch contents.
    input  wire  logic [7:0] host_wdata_in,             // Write data.
    input  wire  logic       tx_last_bit_sent_in,       // Pulse after final transmitted bit.
    input  wire  logic       rx_end_valid_in,           // Pulse at end of a valid receive stream.
    input  wire  logic       suppress_empty_receive_in, // Receive done needs FIFO data when high.
    input  wire  logic [6:0] fifo_count_in,             // Bytes stored in the FIFO, 0 to 64.
    input  wire  logic [5:0] water_level_in,            // FIFO warning level.
    input  wire  logic [7:0] error_bits_in,             // Error register contents.
    input  wire  logic       timer_zero_in,             // Pulse when the timer reaches zero.
    input  wire  logic       command_done_in,           // Pulse when the running command ends itself.
    input  wire  logic       core_ready_in,             // Level, core ready after wake-up.
    input  wire  logic [4:0] secondary_request_in,      // Secondary request bits, held elsewhere.
    output logic       [5:0] reg_addr_out,              // Resolved register address of last access.
    output logic       [7:0] host_rdata_out,            // Read data.
    output logic             host_rvalid_out,           // Pulse, read data valid.
    output logic       [3:0] command_code_out,          // Command currently executing.
    output logic             command_start_out,         // Pulse, a command was started.
    output logic             receiver_analog_off_out,   // Analog receiver switched off.
    output logic             soft_sleep_out,            // Core held in soft sleep.
    output logic             irq_status_out,            // Combined pending-interrupt status.
    output logic             fifo_high_level_status_out,// FIFO high level status.
    output logic             fifo_low_level_status_out, // FIFO low level status.
    output logic             irq_pin_out,               // Interrupt pin output value.
    output logic             irq_pin_oe_out             // Interrupt pin output enable, high drives.
);

    // High level test; the subtraction is done at 8 bits so a count of 64 cannot wrap.
    function automatic logic fifo_high(input logic [6:0] cnt, input logic [5:0] wl);
        logic [7:0] room;
        room = {1'b0, FIFO_DEPTH} - {1'b0, cnt};
        return room <= {2'b00, wl};
    endfunction

    // Stored state.
    logic [7:0] page_reg, page_next;          // Page override and page number.
    logic [7:0] cmd_reg, cmd_next;            // Receiver off, sleep request, command field.
    logic [7:0] en_pri_reg, en_pri_next;      // Pin invert plus seven primary enables.
    logic [7:0] en_sec_reg, en_sec_next;      // Pin drive plus five secondary enables.
    logic [6:0] req_reg, req_next;            // Primary requests; bit seven is never stored.
    pcir_pwr_t  pwr_reg, pwr_next;            // Soft sleep sequencer.
    logic [5:0] addr_reg, addr_next;
    logic [7:0] rdata_reg, rdata_next;
    logic       rvalid_reg, rvalid_next;
    logic       start_reg, start_next;
    logic       irq_reg, irq_next;
    logic       high_reg, high_next;
    logic       low_reg, low_next;
    logic       pin_reg, pin_next;
    logic       oe_reg, oe_next;
    // Decode helpers.
    logic [5:0] addr;
    logic       sel_page, sel_cmd, sel_en_pri, sel_en_sec, sel_req;
    logic       high_now, low_now, pend_now, pin_val, sleep_bit;
    logic [6:0] hw_set;

    // Address resolution and decode.
    always_comb begin
        if (page_reg[BIT_PAGE_OVERRIDE]) begin
            addr = {page_reg[1:0], host_latch_addr_in[3:0]};
        end else begin
            addr = host_latch_addr_in;
        end
        // Page select is visible at offset zero of every page.
        sel_page   = (addr[3:0] == OFS_PAGE_SELECT);
        sel_cmd    = (addr == {PAGE_ZERO, OFS_COMMAND});
        sel_en_pri = (addr == {PAGE_ZERO, OFS_IRQ_EN_PRI});
        sel_en_sec = (addr == {PAGE_ZERO, OFS_IRQ_EN_SEC});
        sel_req    = (addr == {PAGE_ZERO, OFS_IRQ_REQ_PRI});
    end

    // Level status, hardware request sources and the interrupt pin value.
    always_comb begin
        high_now = fifo_high(fifo_count_in, water_level_in);
        low_now  = (fifo_count_in <= {1'b0, water_level_in});
        hw_set = 7'h00;
        hw_set[BIT_TX_DONE] = tx_last_bit_sent_in;
        hw_set[BIT_RX_DONE] = rx_end_valid_in & (~suppress_empty_receive_in | (fifo_count_in != 7'h00));
        hw_set[BIT_FIFO_HIGH] = high_now;
        hw_set[BIT_FIFO_LOW]  = low_now;
        hw_set[BIT_ERROR] = |error_bits_in;
        hw_set[BIT_TIMER] = timer_zero_in;
        if ((command_done_in && cmd_reg[3:0] != CMD_IDLE)
            || (host_wr_in && sel_cmd && !KNOWN_CMD_MASK[host_wdata_in[3:0]])) begin
            hw_set[BIT_IDLE] = 1'b1;
        end
        pend_now = |(req_reg & en_pri_reg[6:0]) | |(secondary_request_in & en_sec_reg[4:0]);
        pin_val = en_pri_reg[BIT_PIN_INVERT] ? ~pend_now : pend_now;
        // sleep bit shows one through wake-up
        sleep_bit = (pwr_reg != PCIR_PWR_RUN);
    end

    // Register writes, internal updates and sleep sequencing.
    always_comb begin
        page_next   = page_reg;
        cmd_next    = cmd_reg;
        en_pri_next = en_pri_reg;
        en_sec_next = en_sec_reg;
        req_next    = req_reg;
        pwr_next    = pwr_reg;
        start_next  = 1'b0;
        // control bits only from host writes
        if (host_wr_in && sel_page) begin
            page_next = host_wdata_in & MASK_PAGE_SELECT;
        end
        if (host_wr_in && sel_en_pri) begin
            en_pri_next = host_wdata_in;
        end
        if (host_wr_in && sel_en_sec) begin
            en_sec_next = host_wdata_in & MASK_IRQ_EN_SEC;
        end
        if (command_done_in) begin
            cmd_next[3:0] = CMD_IDLE;
        end
        if (host_wr_in && sel_cmd) begin
            cmd_next[BIT_RX_OFF] = host_wdata_in[BIT_RX_OFF];
            // start command; unknown codes fall back to idle
            cmd_next[3:0] = KNOWN_CMD_MASK[host_wdata_in[3:0]] ? host_wdata_in[3:0] : CMD_IDLE;
            start_next    = KNOWN_CMD_MASK[host_wdata_in[3:0]] && (host_wdata_in[3:0] != CMD_IDLE);
            if (host_wdata_in[BIT_SLEEP] && cmd_reg[3:0] != CMD_SOFT_RESET
                && host_wdata_in[3:0] != CMD_SOFT_RESET) begin
                pwr_next = PCIR_PWR_SLEEP;
            end else if (!host_wdata_in[BIT_SLEEP] && pwr_reg == PCIR_PWR_SLEEP) begin
                pwr_next = PCIR_PWR_WAKE;
            end
        end
        if (pwr_reg == PCIR_PWR_WAKE && pwr_next == PCIR_PWR_WAKE && core_ready_in) begin
            pwr_next = PCIR_PWR_RUN;
        end
        cmd_next[BIT_SLEEP] = (pwr_next != PCIR_PWR_RUN);
        cmd_next = cmd_next & MASK_COMMAND;
        if (host_wr_in && sel_req) begin
            if (host_wdata_in[BIT_SET_CLEAR_SEL]) begin
                req_next = req_reg | host_wdata_in[6:0];
            end else begin
                req_next = req_reg & ~host_wdata_in[6:0];
            end
        end
        // only host clears; hardware set wins over a same-cycle clear
        req_next = req_next | hw_set;
    end

    // Read path, pin drive and registered outputs.
    always_comb begin
        addr_next   = (host_wr_in || host_rd_in) ? addr : addr_reg;
        rvalid_next = host_rd_in;
        rdata_next  = rdata_reg;
        if (host_rd_in) begin
            rdata_next = 8'h00;
            if (sel_page) begin
                rdata_next = page_reg;
            end else if (sel_cmd) begin
                rdata_next = {cmd_reg[7:5], sleep_bit, cmd_reg[3:0]};
            end else if (sel_en_pri) begin
                rdata_next = en_pri_reg;
            end else if (sel_en_sec) begin
                rdata_next = en_sec_reg;
            end else if (sel_req) begin
                rdata_next = {1'b0, req_reg};
            end
        end
        irq_next  = pend_now;
        high_next = high_now;
        low_next  = low_now;
        if (en_sec_reg[BIT_PIN_CMOS]) begin
            pin_next = pin_val;
            oe_next  = 1'b1;
        end else begin
            pin_next = 1'b0;
            oe_next  = ~pin_val;
        end
    end

    // State registers; reset leaves the pin released under the default settings.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            page_reg   <= RST_PAGE_SELECT;
            cmd_reg    <= RST_COMMAND;
            en_pri_reg <= RST_IRQ_EN_PRI;
            en_sec_reg <= RST_IRQ_EN_SEC;
            req_reg    <= RST_IRQ_REQ_PRI[6:0];
            pwr_reg    <= PCIR_PWR_RUN;
            addr_reg   <= 6'h00;
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
            start_reg  <= 1'b0;
            irq_reg    <= 1'b0;
            high_reg   <= 1'b0;
            low_reg    <= 1'b0;
            pin_reg    <= 1'b0;
            oe_reg     <= 1'b0;
        end else begin
            page_reg   <= page_next;
            cmd_reg    <= cmd_next;
            en_pri_reg <= en_pri_next;
            en_sec_reg <= en_sec_next;
            req_reg    <= req_next;
            pwr_reg    <= pwr_next;
            addr_reg   <= addr_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            start_reg  <= start_next;
            irq_reg    <= irq_next;
            high_reg   <= high_next;
            low_reg    <= low_next;
            pin_reg    <= pin_next;
            oe_reg     <= oe_next;
        end
    end

    assign reg_addr_out               = addr_reg;
    assign host_rdata_out             = rdata_reg;
    assign host_rvalid_out            = rvalid_reg;
    assign command_code_out           = cmd_reg[3:0];
    assign command_start_out          = start_reg;
    assign receiver_analog_off_out    = cmd_reg[BIT_RX_OFF];
    assign soft_sleep_out             = cmd_reg[BIT_SLEEP];
    assign irq_status_out             = irq_reg;
    assign fifo_high_level_status_out = high_reg;
    assign fifo_low_level_status_out  = low_reg;
    assign irq_pin_out                = pin_reg;
    assign irq_pin_oe_out             = oe_reg;

    // Checks on the design's own outputs and request register.
    AST_WO_ZERO: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        host_rd_in && sel_req |=> host_rdata_out[7] == 1'b0) else $error("select bit read nonzero");
    AST_RSV_ZERO: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        host_rdata_out[6:2] == 5'h00 || $past(!sel_page || !host_rd_in)) else $error("page reserved bits set");
    AST_RX_OFF: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        host_wr_in && sel_cmd |=> receiver_analog_off_out == $past(host_wdata_in[BIT_RX_OFF]))
        else $error("receiver off not taken");
    AST_SLEEP_REFUSE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        host_wr_in && sel_cmd && !soft_sleep_out
        && (cmd_reg[3:0] == CMD_SOFT_RESET || host_wdata_in[3:0] == CMD_SOFT_RESET) |=> !soft_sleep_out)
        else $error("sleep set during reset");
    AST_WAKE_HOLD: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        pwr_reg == PCIR_PWR_WAKE && !core_ready_in |=> soft_sleep_out) else $error("sleep bit dropped early");
    AST_REQ_SET: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        host_wr_in && sel_req && host_wdata_in[7] |=> ((req_reg & $past(host_wdata_in[6:0])) == $past(host_wdata_in[6:0])))
        else $error("marked request not set");
    AST_TX_SET: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        tx_last_bit_sent_in |=> req_reg[BIT_TX_DONE]) else $error("transmit done missed");
    AST_ERR_SET: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        error_bits_in != 8'h00 |=> req_reg[BIT_ERROR]) else $error("error request missed");
    AST_NO_SELF_CLEAR: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        !(host_wr_in && sel_req) |=> (req_reg & $past(req_reg)) == $past(req_reg)) else $error("request lost");
    AST_PIN: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        ##1 en_sec_reg[BIT_PIN_CMOS] && $stable(en_sec_reg) && $stable(en_pri_reg) |->
        irq_pin_oe_out && irq_pin_out == (irq_status_out ^ en_pri_reg[BIT_PIN_INVERT])) else $error("pin level wrong");
    AST_IDLE_UNKNOWN: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in)
        host_wr_in && sel_cmd && !KNOWN_CMD_MASK[host_wdata_in[3:0]] |=> req_reg[BIT_IDLE] && command_code_out == CMD_IDLE)
        else $error("unknown command not reverted");

    COV_READ_REQ: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in) host_rd_in && sel_req ##1 host_rvalid_out);
    COV_WAKE: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in) pwr_reg == PCIR_PWR_WAKE ##1 pwr_reg == PCIR_PWR_RUN);
    COV_IRQ_PIN: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in) !irq_status_out ##1 irq_status_out);
    COV_OVERRIDE: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in) page_reg[BIT_PAGE_OVERRIDE] && host_wr_in);

endmodule
`default_nettype wire

// File: testbench/pcir_host_model.sv
// Host microcontroller model that drives the register strobes of the front end.
`timescale 1ns/1ps
`default_nettype none
module pcir_host_model (
    input  wire logic       clk_in,    // Core clock.
    input  wire logic [7:0] rdata_in,  // Read data from the block.
    input  wire logic       rvalid_in, // Read data valid pulse.
    output logic            wr_out,    // Write strobe.
    output logic            rd_out,    // Read strobe.
    output logic      [5:0] addr_out,  // Address latch contents.
    output logic      [7:0] wdata_out  // Write data.
);
    // Idle bus at time zero so the block never sees an unknown strobe.
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = 6'h00;
        wdata_out = 8'h00;
    end
    // One-cycle write strobe; data is flipped afterwards so a stale byte is never mistaken for valid.
    task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_out <= 1'b1;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clk_in);
        wr_out <= 1'b0;
        wdata_out <= ~d;
    endtask
    // One-cycle read strobe; the answer is fixed one cycle later, so no wait loop is needed.
    task automatic read_reg(input logic [5:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk_in);
        rd_out <= 1'b1;
        addr_out <= a;
        @(posedge clk_in);
        rd_out <= 1'b0;
        #1;
        ok = (rvalid_in === 1'b1);
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

// File: testbench/pcir_regs_test.sv
// Self-checking bench for the page, command and interrupt register front end.
`timescale 1ns/1ps
`default_nettype none
module pcir_regs_test;
    import pcir_pkg::*;
    logic       sys_clk_in, arst_n_in, host_wr_in, host_rd_in, suppress_empty_receive_in, core_ready_in;
    logic [5:0] host_latch_addr_in, water_level_in, reg_addr_out;
    logic [7:0] host_wdata_in, error_bits_in, host_rdata_out;
    logic [6:0] fifo_count_in;
    logic [4:0] secondary_request_in;
    logic [3:0] ev;  // Event pulses: transmit, receive, timer, command end.
    logic [3:0] command_code_out;
    logic       host_rvalid_out, command_start_out, receiver_analog_off_out, soft_sleep_out, irq_status_out;
    logic       fifo_high_level_status_out, fifo_low_level_status_out, irq_pin_out, irq_pin_oe_out;
    int         errors, total_checks;
    logic [7:0] rst_tbl [5] = '{8'h00, 8'h20, 8'h80, 8'h00, 8'h14};
    logic [6:0] cnt_tbl [4] = '{7'h3C, 7'h3B, 7'h04, 7'h05};
    // Command code 2 is treated as unknown so the revert path is reachable.
    pcir_regs #(.KNOWN_CMD_MASK(16'hFFFB)) i_dut (
        .sys_clk_in, .arst_n_in, .host_wr_in, .host_rd_in, .host_latch_addr_in, .host_wdata_in,
        .tx_last_bit_sent_in(ev[0]), .rx_end_valid_in(ev[1]), .timer_zero_in(ev[2]), .command_done_in(ev[3]),
        .suppress_empty_receive_in, .fifo_count_in, .water_level_in, .error_bits_in, .core_ready_in,
        .secondary_request_in, .reg_addr_out, .host_rdata_out, .host_rvalid_out, .command_code_out,
        .command_start_out, .receiver_analog_off_out, .soft_sleep_out, .irq_status_out,
        .fifo_high_level_status_out, .fifo_low_level_status_out, .irq_pin_out, .irq_pin_oe_out);
    pcir_host_model i_host (.clk_in(sys_clk_in), .rdata_in(host_rdata_out), .rvalid_in(host_rvalid_out),
        .wr_out(host_wr_in), .rd_out(host_rd_in), .addr_out(host_latch_addr_in), .wdata_out(host_wdata_in));
    // Free-running 20 MHz clock.
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    task automatic conclude();
        if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        check({7'h00, got}, {7'h00, exp});
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        i_host.read_reg(a, d, ok);
        chk1(ok, 1'b1);
        check(d, exp);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        i_host.write_reg(a, d);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic pulse(input int i);
        @(posedge sys_clk_in) ev[i] <= 1'b1;
        @(posedge sys_clk_in) ev[i] <= 1'b0;
    endtask
    // Watchdog: a hang counts as a mismatch and ends the run.
    initial begin
        #1000000;
        errors++;
        conclude();
    end
    initial begin
        errors = 0;
        total_checks = 0;
        arst_n_in = 1'b0;
        ev = 4'h0;
        suppress_empty_receive_in = 1'b0;
        core_ready_in = 1'b0;
        fifo_count_in = 7'h0A;
        water_level_in = 6'h00;
        error_bits_in = 8'h00;
        secondary_request_in = 5'h00;
        repeat (8) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        tick(1);
        chk1(irq_pin_oe_out, 1'b0);
        chk1(receiver_analog_off_out, 1'b1);
        for (int i = 0; i < 5; i++) rd_chk(i[5:0], rst_tbl[i]);
        tick(1);
        chk1(host_rvalid_out, 1'b0);
        check(host_rdata_out, RST_IRQ_REQ_PRI);
        // Page override routes the page field onto the upper address bits.
        wr(6'h00, 8'hFF);
        rd_chk(6'h00, 8'h83);
        rd_chk(6'h01, 8'h00);
        check({2'b00, reg_addr_out}, 8'h31);
        wr(6'h00, 8'h01);
        rd_chk(6'h01, 8'h20);
        check({2'b00, reg_addr_out}, 8'h01);
        wr(6'h00, 8'h00);
        wr(6'h03, 8'hFF);
        rd_chk(6'h03, 8'h9F);
        wr(6'h02, 8'h7F);
        rd_chk(6'h02, 8'h7F);
        // Command start, self end, host idle and unknown code.
        wr(6'h04, 8'h7F);
        wr(6'h01, 8'h03);
        #1 chk1(command_start_out, 1'b1);
        chk1(receiver_analog_off_out, 1'b0);
        rd_chk(6'h01, 8'h03);
        pulse(3);
        rd_chk(6'h01, 8'h00);
        rd_chk(6'h04, 8'h10);
        wr(6'h04, 8'h10);
        wr(6'h01, {4'h0, CMD_IDLE});
        #1 chk1(command_start_out, 1'b0);
        rd_chk(6'h04, 8'h00);
        wr(6'h01, 8'h02);
        #1 chk1(command_start_out, 1'b0);
        rd_chk(6'h01, 8'h00);
        rd_chk(6'h04, 8'h10);
        // Sleep entry, wake-up while the core is not ready, and refusal under software reset.
        wr(6'h01, 8'h30);
        #1 chk1(soft_sleep_out, 1'b1);
        chk1(receiver_analog_off_out, 1'b1);
        wr(6'h01, 8'h20);
        rd_chk(6'h01, 8'h30);
        @(posedge sys_clk_in) core_ready_in <= 1'b1;
        tick(2);
        rd_chk(6'h01, 8'h20);
        @(posedge sys_clk_in) core_ready_in <= 1'b0;
        wr(6'h01, {4'h1, CMD_SOFT_RESET});
        rd_chk(6'h01, 8'h0F);
        // A sleep request while software reset still runs is refused as well.
        wr(6'h01, 8'h10);
        rd_chk(6'h01, 8'h00);
        chk1(soft_sleep_out, 1'b0);
        pulse(3);
        // Set and clear selection; nothing clears a request but the host.
        wr(6'h04, 8'h7F);
        wr(6'h04, 8'hC1);
        rd_chk(6'h04, 8'h41);
        tick(20);
        rd_chk(6'h04, 8'h41);
        wr(6'h04, 8'h40);
        rd_chk(6'h04, 8'h01);
        wr(6'h04, 8'h01);
        pulse(0);
        rd_chk(6'h04, 8'h40);
        wr(6'h04, 8'h40);
        @(posedge sys_clk_in) suppress_empty_receive_in <= 1'b1;
        fifo_count_in <= 7'h00;
        pulse(1);
        rd_chk(6'h04, 8'h04);
        @(posedge sys_clk_in) fifo_count_in <= 7'h0A;
        wr(6'h04, 8'h04);
        pulse(1);
        pulse(2);
        rd_chk(6'h04, 8'h21);
        @(posedge sys_clk_in) error_bits_in <= 8'h40;
        @(posedge sys_clk_in) error_bits_in <= 8'h00;
        wr(6'h04, 8'h21);
        rd_chk(6'h04, 8'h02);
        wr(6'h04, 8'h02);
        // Level compares at both boundaries, then the latched alert requests.
        @(posedge sys_clk_in) water_level_in <= 6'h04;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk_in) fifo_count_in <= cnt_tbl[i];
            tick(3);
            chk1(fifo_high_level_status_out, i == 0);
            chk1(fifo_low_level_status_out, i == 2);
        end
        rd_chk(6'h04, 8'h0C);
        wr(6'h04, 8'h0C);
        rd_chk(6'h04, 8'h00);
        // Each primary source reaches the inverted open-drain pin only when enabled.
        wr(6'h03, 8'h00);
        for (int i = 0; i < 7; i++) begin
            wr(6'h02, 8'h80 | (8'h01 << i));
            wr(6'h04, 8'h80 | (8'h01 << i));
            tick(3);
            chk1(irq_status_out, 1'b1);
            chk1(irq_pin_oe_out, 1'b1);
            chk1(irq_pin_out, 1'b0);
            wr(6'h02, 8'h80);
            tick(3);
            chk1(irq_status_out, 1'b0);
            chk1(irq_pin_oe_out, 1'b0);
            wr(6'h04, 8'h01 << i);
        end
        wr(6'h03, 8'h80);
        wr(6'h02, 8'h01);
        wr(6'h04, 8'h81);
        tick(3);
        chk1(irq_pin_oe_out, 1'b1);
        chk1(irq_pin_out, 1'b1);
        wr(6'h02, 8'h81);
        tick(3);
        chk1(irq_pin_out, 1'b0);
        wr(6'h04, 8'h01);
        // Each secondary source is gated by its own enable only.
        for (int i = 0; i < 5; i++) begin
            wr(6'h03, 8'h80 | (8'h01 << i));
            @(posedge sys_clk_in) secondary_request_in <= 5'h1F ^ (5'h01 << i);
            tick(3);
            chk1(irq_status_out, 1'b0);
            @(posedge sys_clk_in) secondary_request_in <= 5'h01 << i;
            tick(3);
            chk1(irq_status_out, 1'b1);
        end
        conclude();
    end
endmodule
`default_nettype wire
